/* File: inc/asrs_pkg.sv */
// Purpose: Shared constants and types of the serial receiver block
// Assumes: 32-bit APB, one word per register
// Notes:   Field positions are bit indices inside the 8-bit registers
`default_nettype none
package asrs_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_DATA   = 4'h0;
    localparam logic [3:0] ADDR_CSR_A  = 4'h4;
    localparam logic [3:0] ADDR_CSR_B  = 4'h8;
    localparam logic [3:0] ADDR_CSR_C  = 4'hC;
    // ctrl_status_a fields
    localparam int A_RXC   = 7;
    localparam int A_FERR  = 4;
    localparam int A_OVR   = 3;
    localparam int A_PERR  = 2;
    localparam int A_DBL   = 1;
    // ctrl_status_b fields
    localparam int B_IRQEN = 7;
    localparam int B_RX_ENABLE_BIT  = 4;
    localparam int B_SZ2   = 2;
    localparam int B_NINTH = 1;
    // ctrl_status_c fields
    localparam int C_PAR   = 5;
    localparam int C_ODD   = 4;
    localparam int C_TWOSB = 3;
    localparam int C_SZLO  = 1;
    // Reset values
    localparam logic       DBL_RST   = 1'b0;
    localparam logic       IRQEN_RST = 1'b0;
    localparam logic       RX_ENABLE_BIT_RST  = 1'b0;
    localparam logic [2:0] SIZE_RST  = 3'h3;
    // Character size code for nine data bits
    localparam logic [2:0] SIZE_NINE = 3'h7;
    // Oversampling: samples per bit and centre vote window
    localparam logic [4:0] NRM_SPB   = 5'h10;
    localparam logic [4:0] NRM_V1    = 5'h08;
    localparam logic [4:0] NRM_V3    = 5'h0A;
    localparam logic [4:0] DBL_SPB   = 5'h08;
    localparam logic [4:0] DBL_V1    = 5'h04;
    localparam logic [4:0] DBL_V3    = 5'h06;
    // Receive FIFO depth
    localparam int FIFO_DEPTH = 2;
    // One stored frame
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       ferr;
        logic       ovr;
        logic       perr;
    } asrs_entry_t;
    // Frame reception states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100
    } asrs_state_t;
endpackage
`default_nettype wire

/* File: design/asrs_receiver.sv */
// Purpose: Receive half of an asynchronous serial port with APB registers
// Assumes: sample_tick pulses at 16x baud (8x in double speed)
// Notes:   Two-frame receive FIFO plus one frame held in the shifter
//
// Overview of operation
// [RULE1] Ninth bit presented; read before data
// [RULE2] Data read advances FIFO and its flags
// [RULE3] Software reads status before data
// [RULE4] Complete flag high while FIFO holds data
// [RULE5] Clearing enable flushes FIFO, clears flag
// [RULE6] Interrupt follows complete flag when enabled
// [RULE7] Error flags stored with each frame
// [RULE8] Writes to error flags are ignored
// [RULE9] Software writes zero to error flags
// [RULE10] Error flags raise no interrupt
// [RULE11] Stop error when first stop low
// [RULE12] Only first stop bit is checked
// [RULE13] Overrun: FIFO full, held frame, start
// [RULE14] Overrun cleared when frame enters FIFO
// [RULE15] Parity checked only when enabled
// [RULE16] Parity error needs check enabled then
// [RULE17] Parity error reads zero when disabled
// [RULE18] Disable drops frame, releases pin
// [RULE19] Software drains by reading until empty
// [RULE20] Sample 16x normal, 8x double speed
// [RULE21] Counter stays zero while line idle
// [RULE22] Start bit voted on samples 8-10/4-6
// [RULE23] Bits decided by centre majority vote
// [RULE24] First stop bit moves frame; second ignored
// [RULE25] Unused high data bits read zero
// [RULE26] Odd select zero even, one odd
// [RULE27] FIFO holds two frames in order
`default_nettype none
module asrs_receiver
    import asrs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_tick,
    input  wire logic        rx_serial_in,
    output logic             rx_irq,
    output logic             rx_pin_override
);

    // Majority of three samples, given the count of high samples
    function automatic logic vote(input logic [1:0] highs);
        vote = highs[1];
    endfunction

    // Keep only the received data bits of a character
    function automatic logic [7:0] mask_data(input logic [8:0] sh,
                                             input logic [3:0] nbits);
        logic [7:0] m;
        m = 8'hFF >> (4'h8 - ((nbits > 4'h8) ? 4'h8 : nbits));
        mask_data = sh[7:0] & m;
    endfunction

    // Software controlled bits
    logic        dbl_reg;      // Double speed select
    logic        irqen_reg;    // Receive complete interrupt enable
    logic        rx_enable_bit_reg;     // Receiver enable
    logic [2:0]  size_reg;     // Character size code
    logic        par_reg;      // Parity check on
    logic        odd_reg;      // Odd parity select
    logic        twosb_reg;    // Two stop bits (no effect on receiving)

    // Receive engine
    asrs_state_t state_reg;    // Frame state
    logic [4:0]  smp_reg;      // Sample number inside current bit
    logic [1:0]  highs_reg;    // High samples seen in vote window
    logic [3:0]  bit_reg;      // Data bit index
    logic [8:0]  shift_reg;    // Data bits as received
    logic        pbit_reg;     // Received parity bit
    logic        line_reg;     // Line level at previous tick

    // Frame waiting in the shifter while FIFO is full
    asrs_entry_t hold_reg;
    logic        hold_v_reg;
    logic        ovr_reg;      // Overrun pending for next pushed frame

    // Receive FIFO
    asrs_entry_t mem_reg [FIFO_DEPTH];
    logic        rd_ptr_reg;
    logic        wr_ptr_reg;
    logic [1:0]  cnt_reg;

    // APB return path
    logic        ack_reg;      // Second access cycle, answer ready
    logic [31:0] prdata_reg;
    logic        err_reg;

    // Decode of the access phase
    wire         acc       = psel & penable;
    wire         sel_data  = (paddr[3:0] == ADDR_DATA);
    wire         sel_a     = (paddr[3:0] == ADDR_CSR_A);
    wire         sel_b     = (paddr[3:0] == ADDR_CSR_B);
    wire         sel_c     = (paddr[3:0] == ADDR_CSR_C);
    wire         mapped    = (paddr[31:4] == 28'h0) & (paddr[1:0] == 2'h0);
    wire         done      = acc & ack_reg;
    wire         wr_done   = done & pwrite & mapped;
    wire         pop       = done & ~pwrite & mapped & sel_data & (cnt_reg != 2'h0);

    // Mode dependent sampling figures
    wire [4:0]   spb       = dbl_reg ? DBL_SPB : NRM_SPB;  // [RULE20]
    wire [4:0]   v1        = dbl_reg ? DBL_V1 : NRM_V1;
    wire [4:0]   v3        = dbl_reg ? DBL_V3 : NRM_V3;
    wire [4:0]   smp_now   = smp_reg + 5'h01;               // Sample number of this tick
    wire         in_win    = (smp_now >= v1) & (smp_now <= v3);
    wire [1:0]   highs_now = highs_reg + {1'b0, rx_serial_in};
    wire         bit_val   = vote(highs_now);               // [RULE23]
    wire         at_vote   = sample_tick & (smp_now == v3);
    wire         at_end    = sample_tick & (smp_reg == spb);

    // Character length in data bits
    wire         nine      = (size_reg == SIZE_NINE);
    wire [3:0]   nbits     = nine ? 4'h9 : {2'h0, size_reg[1:0]} + 4'h5;

    // FIFO occupancy
    wire         empty     = (cnt_reg == 2'h0);
    wire         full      = (cnt_reg == 2'(FIFO_DEPTH));
    asrs_entry_t head;
    assign head = mem_reg[rd_ptr_reg];

    // Events of the frame engine
    wire         fall      = sample_tick & line_reg & ~rx_serial_in;
    wire         start_det = (state_reg == ST_IDLE) & fall;
    wire         stop_done = (state_reg == ST_STOP) & at_vote;

    // Parity compare: even wants xor of bits and parity to be zero
    wire         par_calc  = ^mask_data(shift_reg, nbits) ^ (nine & shift_reg[8]);
    wire         par_bad   = par_reg & ((par_calc ^ pbit_reg) != odd_reg); // [RULE15] [RULE26]

    // Finished frame as it will be stored
    asrs_entry_t new_entry;
    assign new_entry.data  = mask_data(shift_reg, nbits);  // [RULE25]
    assign new_entry.ninth = nine & shift_reg[8];          // [RULE1]
    assign new_entry.ferr  = ~bit_val;                     // [RULE11] [RULE12]
    assign new_entry.ovr   = 1'b0;
    assign new_entry.perr  = par_bad;                      // [RULE16]

    // Push source: the held frame has priority over a newly finished one
    wire         room      = ~full | pop;
    wire         push_hold = rx_enable_bit_reg & hold_v_reg & room;
    wire         push_new  = rx_enable_bit_reg & stop_done & ~hold_v_reg & room;
    wire         push      = push_hold | push_new;
    asrs_entry_t push_entry;
    assign push_entry = push_hold ? hold_reg : new_entry;

    // Register read multiplexer
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_data) begin
            rd_byte = empty ? 8'h00 : head.data;
        end else if (sel_a) begin
            rd_byte[A_RXC]  = ~empty;                       // [RULE4]
            rd_byte[A_FERR] = ~empty & head.ferr;           // [RULE7]
            rd_byte[A_OVR]  = ~empty & head.ovr;
            rd_byte[A_PERR] = ~empty & head.perr & par_reg; // [RULE17]
            rd_byte[A_DBL]  = dbl_reg;
        end else if (sel_b) begin
            rd_byte[B_IRQEN] = irqen_reg;
            rd_byte[B_RX_ENABLE_BIT]  = rx_enable_bit_reg;
            rd_byte[B_SZ2]   = size_reg[2];
            rd_byte[B_NINTH] = ~empty & head.ninth;         // [RULE1]
        end else if (sel_c) begin
            rd_byte[C_PAR]   = par_reg;
            rd_byte[C_ODD]   = odd_reg;
            rd_byte[C_TWOSB] = twosb_reg;
            rd_byte[C_SZLO+1:C_SZLO] = size_reg[1:0];
        end
    end

    // APB answer: captured in the first access cycle, ready in the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg    <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else begin
            ack_reg <= acc & ~ack_reg;
            if (acc & ~ack_reg) begin
                prdata_reg <= (mapped & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                err_reg    <= ~mapped;
            end
        end
    end

    assign pready  = done;
    assign prdata  = prdata_reg;
    assign pslverr = done & err_reg;

    // Control register writes; error flag positions are read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbl_reg   <= DBL_RST;
            irqen_reg <= IRQEN_RST;
            rx_enable_bit_reg  <= RX_ENABLE_BIT_RST;
            size_reg  <= SIZE_RST;
            par_reg   <= 1'b0;
            odd_reg   <= 1'b0;
            twosb_reg <= 1'b0;
        end else if (wr_done) begin
            if (sel_a) begin
                dbl_reg <= pwdata[A_DBL];                   // [RULE8]
            end else if (sel_b) begin
                irqen_reg   <= pwdata[B_IRQEN];
                rx_enable_bit_reg    <= pwdata[B_RX_ENABLE_BIT];
                size_reg[2] <= pwdata[B_SZ2];
            end else if (sel_c) begin
                par_reg       <= pwdata[C_PAR];
                odd_reg       <= pwdata[C_ODD];
                twosb_reg     <= pwdata[C_TWOSB];
                size_reg[1:0] <= pwdata[C_SZLO+1:C_SZLO];
            end
        end
    end

    // Line history for falling edge detection at the sample rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_reg <= 1'b1;
        end else if (!rx_enable_bit_reg) begin
            line_reg <= 1'b1;
        end else if (sample_tick) begin
            line_reg <= rx_serial_in;
        end
    end

    // Frame state machine; disabling stops it at once
    asrs_state_t state_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fall) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                if (at_vote && bit_val) begin
                    state_next = ST_IDLE;                   // [RULE22]
                end else if (at_end) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (at_end && (bit_reg == nbits - 4'h1)) begin
                    state_next = par_reg ? ST_PAR : ST_STOP;
                end
            end
            ST_PAR: begin
                if (at_end) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (at_vote) begin
                    state_next = ST_IDLE;                   // [RULE24]
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!rx_enable_bit_reg) begin
            state_next = ST_IDLE;                           // [RULE18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sample counter and centre vote tally
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_reg   <= 5'h00;
            highs_reg <= 2'h0;
        end else if (state_next == ST_IDLE) begin
            smp_reg   <= 5'h00;                             // [RULE21]
            highs_reg <= 2'h0;
        end else if (sample_tick) begin
            // First low sample counts as one
            smp_reg <= (state_reg == ST_IDLE || smp_reg == spb) ? 5'h01 : smp_reg + 5'h01;
            if (state_reg == ST_IDLE || smp_reg == spb) begin
                highs_reg <= 2'h0;
            end else if (in_win) begin
                highs_reg <= highs_now;
            end
        end
    end

    // Data bit shifter and parity capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_reg   <= 4'h0;
            shift_reg <= 9'h000;
            pbit_reg  <= 1'b0;
        end else if (start_det) begin
            bit_reg   <= 4'h0;
            shift_reg <= 9'h000;
        end else if (at_vote && state_reg == ST_DATA) begin
            shift_reg[bit_reg] <= bit_val;                  // [RULE23]
        end else if (at_end && state_reg == ST_DATA) begin
            bit_reg <= bit_reg + 4'h1;
        end else if (at_vote && state_reg == ST_PAR) begin
            pbit_reg <= bit_val;
        end
    end

    // Held frame and overrun tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_v_reg <= 1'b0;
            hold_reg   <= '0;
            ovr_reg    <= 1'b0;
        end else if (!rx_enable_bit_reg) begin
            hold_v_reg <= 1'b0;                             // [RULE5]
            ovr_reg    <= 1'b0;
        end else begin
            // Frame finishing with no room waits in the shifter
            if (stop_done && !hold_v_reg && !room) begin
                hold_v_reg <= 1'b1;
                hold_reg   <= new_entry;
            end else if (push_hold) begin
                hold_v_reg <= 1'b0;
            end
            // Loss is flagged on the next frame that reaches the FIFO
            if (start_det && full && hold_v_reg && !pop) begin
                ovr_reg <= 1'b1;                            // [RULE13]
            end else if (push) begin
                ovr_reg <= 1'b0;                            // [RULE14]
            end
        end
    end

    // Two-entry FIFO in flip-flops; disable empties it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (!rx_enable_bit_reg) begin
            rd_ptr_reg <= 1'b0;                             // [RULE5]
            wr_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg]     <= push_entry;      // [RULE27] [RULE7]
                mem_reg[wr_ptr_reg].ovr <= ovr_reg;
                wr_ptr_reg              <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;                  // [RULE2]
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // Interrupt request from data presence only, never from error flags
    assign rx_irq          = irqen_reg & ~empty;            // [RULE6] [RULE10]
    assign rx_pin_override = rx_enable_bit_reg;                      // [RULE18]

endmodule
`default_nettype wire

/* File: verification/asrs_receiver_props.sv */
// Purpose: Port-level checks of the serial receiver block
// Assumes: The bus master holds each request until pready
// Notes:   Enable shadows follow completed writes only
`default_nettype none
module asrs_receiver_props
    import asrs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_tick,
    input wire logic        rx_serial_in,
    input wire logic        rx_irq,
    input wire logic        rx_pin_override
);
    // Full byte addresses of the control words
    localparam logic [31:0] AD_A = {28'h0, ADDR_CSR_A};
    localparam logic [31:0] AD_B = {28'h0, ADDR_CSR_B};
    localparam logic [31:0] AD_C = {28'h0, ADDR_CSR_C};
    wire logic wr_ok  = pready && pwrite && !pslverr;           // Accepted write
    wire logic rd_a   = pready && !pwrite && (paddr == AD_A);  // Status read
    wire logic bad_ad = (paddr[31:4] != 28'h0) || (paddr[1:0] != 2'h0);
    logic      irqen_h;                                        // Interrupt enable shadow
    logic      par_h;                                          // Parity enable shadow

    // Enable shadows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqen_h <= 1'b0;
            par_h   <= 1'b0;
        end else if (wr_ok && paddr == AD_B) begin
            irqen_h <= pwdata[B_IRQEN];
        end else if (wr_ok && paddr == AD_C) begin
            par_h <= pwdata[C_PAR];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup cycle, then one waiting access cycle, then the answer
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && !pready ##1 pready;
    endsequence

    apb_timing_a: assert property (setup_s |=> answer_s)
        else $error("late bus answer");
    ready_phase_a: assert property (pready |-> psel && penable && $past(penable))
        else $error("ready outside access phase");
    bad_addr_a: assert property (pready && bad_ad |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper bits set");
    irq_enable_a: assert property (rx_irq |-> irqen_h)
        else $error("irq without enable");
    irq_flush_a: assert property (rx_irq |-> rx_pin_override || $past(rx_pin_override))
        else $error("irq after disable");
    rxc_match_a: assert property (rd_a && irqen_h |-> prdata[A_RXC] == $past(rx_irq))
        else $error("complete flag vs irq");
    perr_masked_a: assert property (rd_a && !par_h |-> !prdata[A_PERR])
        else $error("parity flag while off");
    pin_follow_a: assert property (wr_ok && paddr == AD_B |=>
        rx_pin_override == $past(pwdata[B_RX_ENABLE_BIT]))
        else $error("pin override vs enable");
    pin_stable_a: assert property (!(pready && pwrite) |=> $stable(rx_pin_override))
        else $error("pin override moved");
endmodule
bind asrs_receiver asrs_receiver_props u_props (.*);
`default_nettype wire

/* File: verification/asrs_tx_model.sv */
// Purpose: Remote transmitter driving the serial receive line
// Assumes: A bit lasts 16 sample ticks, 8 in double speed
// Notes:   Parity and stop faults happen only on request
`default_nettype none
module asrs_tx_model
    import asrs_pkg::*;
(
    input  wire logic pclk,
    input  wire logic sample_tick,
    input  wire logic dbl,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mark level while idle
    initial line = 1'b1;

    // Hold one bit level for a full bit time
    task automatic hold_bit(input logic b);
        line <= b;
        repeat (dbl ? 8 : 16) @(posedge pclk iff sample_tick);
    endtask

    // Frame: start, data LSB first, optional parity, stop, idle gap
    task automatic send(input logic [8:0] d, input int nb, input logic par,
                        input logic odd, input logic bad, input logic stop1);
        logic p;
        p = (^(d & ((9'h001 << nb) - 9'h001))) ^ odd ^ bad;
        hold_bit(1'b0);
        for (int i = 0; i < nb; i++) begin
            hold_bit(d[i]);
        end
        if (par) begin
            hold_bit(p);
        end
        hold_bit(stop1);
        // Gap gives the receiver time to store the frame
        hold_bit(1'b1);
    endtask

    // Short low glitch, too brief to pass the start vote
    task automatic spike();
        line <= 1'b0;
        repeat (3) @(posedge pclk iff sample_tick);
        hold_bit(1'b1);
        hold_bit(1'b1);
    endtask
endmodule
`default_nettype wire

/* File: verification/asrs_receiver_tb.sv */
// Purpose: Self-checking bench of the serial receiver block
// Assumes: Sample tick every fourth clock, registers over APB
// Notes:   Frames come from the transmitter model
`default_nettype none
module asrs_receiver_tb
    import asrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CD  = {28'h0, ADDR_DATA};
    localparam logic [31:0] CA  = {28'h0, ADDR_CSR_A};
    localparam logic [31:0] CB  = {28'h0, ADDR_CSR_B};
    localparam logic [31:0] CC  = {28'h0, ADDR_CSR_C};
    localparam logic [31:0] RX_COMPLETE_FLAG = 32'h1 << A_RXC;
    localparam logic [31:0] BON = (32'h1 << B_IRQEN) | (32'h1 << B_RX_ENABLE_BIT);
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sample_tick, dbl, rx_serial_in, rx_irq, rx_pin_override, last_err;
    logic [31:0] paddr, pwdata, prdata;
    logic [1:0]  tdiv = 2'h0;
    int          n_mismatch, num_checks;

    // Clock and sample tick divider
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        tdiv        <= tdiv + 2'h1;
        sample_tick <= (tdiv == 2'h3);
    end

    asrs_receiver u_asrs_receiver (.*);
    asrs_tx_model u_asrs_tx_model (.pclk(pclk), .sample_tick(sample_tick), .dbl(dbl),
        .line(rx_serial_in));

    // Count and report one comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // APB transfer held until pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) n_mismatch++;
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, exp, r);
    endtask

    task automatic send(input logic [8:0] d);
        u_asrs_tx_model.send(d, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    endtask

    // Single place where the run ends
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the run
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, dbl} = 5'h00;
        {paddr, pwdata} = 64'h0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped word
        rd("csr_a", CA, 32'h0);
        rd("csr_b", CB, 32'h0);
        rd("csr_c", CC, 32'h06);
        rd("unmapped", 32'h10, 32'h0);
        chk("pslverr", 32'h1, {31'h0, last_err});
        wr(CB, BON);
        rd("csr_b", CB, BON);
        chk("pin_override", 32'h1, {31'h0, rx_pin_override});
        // Plain frame, status then data
        send(9'h0A5);
        chk("rx_irq", 32'h1, {31'h0, rx_irq});
        rd("csr_a", CA, RX_COMPLETE_FLAG);
        rd("data", CD, 32'hA5);
        rd("csr_a", CA, 32'h0);
        // Four frames unread: two stored, one held, one lost
        for (int i = 1; i <= 4; i++) send(9'(i * 17));
        for (int i = 1; i <= 3; i++) begin
            rd("csr_a", CA, RX_COMPLETE_FLAG | ((i == 3) ? (32'h1 << A_OVR) : 32'h0));
            rd("data", CD, 32'(i * 17));
        end
        rd("csr_a", CA, 32'h0);
        send(9'h055);
        rd("csr_a", CA, RX_COMPLETE_FLAG);
        rd("data", CD, 32'h55);
        // Bad first stop with two stop bits selected
        wr(CC, 32'h06 | (32'h1 << C_TWOSB));
        u_asrs_tx_model.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b0);
        rd("csr_a", CA, RX_COMPLETE_FLAG | (32'h1 << A_FERR));
        rd("data", CD, 32'h3C);
        // Parity kinds, good and bad
        for (int k = 0; k < 4; k++) begin
            wr(CC, 32'h26 | (32'(k / 2) << C_ODD));
            u_asrs_tx_model.send(9'h096, 8, 1'b1, k[1], k[0], 1'b1);
            rd("csr_a", CA, RX_COMPLETE_FLAG | (32'(k % 2) << A_PERR));
            rd("data", CD, 32'h96);
        end
        // Stored parity error masked when off
        u_asrs_tx_model.send(9'h096, 8, 1'b1, 1'b1, 1'b1, 1'b1);
        wr(CC, 32'h06);
        rd("csr_a", CA, RX_COMPLETE_FLAG);
        rd("data", CD, 32'h96);
        // Nine-bit frames
        wr(CB, BON | (32'h1 << B_SZ2));
        u_asrs_tx_model.send(9'h1A5, 9, 1'b0, 1'b0, 1'b0, 1'b1);
        u_asrs_tx_model.send(9'h05A, 9, 1'b0, 1'b0, 1'b0, 1'b1);
        rd("csr_b", CB, BON | (32'h1 << B_SZ2) | (32'h1 << B_NINTH));
        rd("data", CD, 32'hA5);
        rd("csr_b", CB, BON | (32'h1 << B_SZ2));
        rd("data", CD, 32'h5A);
        // Five-bit frame, upper data bits read zero
        wr(CB, BON);
        wr(CC, 32'h00);
        u_asrs_tx_model.send(9'h1FF, 5, 1'b0, 1'b0, 1'b0, 1'b1);
        rd("data", CD, 32'h1F);
        wr(CC, 32'h06);
        // Noise glitch is not a start bit
        u_asrs_tx_model.spike();
        rd("csr_a", CA, 32'h0);
        // Double speed, flags written zero
        dbl <= 1'b1;
        wr(CA, 32'h1 << A_DBL);
        send(9'h05A);
        rd("csr_a", CA, RX_COMPLETE_FLAG | (32'h1 << A_DBL));
        rd("data", CD, 32'h5A);
        dbl <= 1'b0;
        wr(CA, 32'h0);
        // Disable flushes stored frames and frees the pin
        send(9'h011);
        send(9'h022);
        wr(CB, 32'h0);
        rd("csr_a", CA, 32'h0);
        rd("data", CD, 32'h0);
        chk("pin_override", 32'h0, {31'h0, rx_pin_override});
        // Disable in mid-frame drops it
        wr(CB, BON);
        fork
            send(9'h077);
            begin
                repeat (300) @(posedge pclk);
                wr(CB, 32'h0);
            end
        join
        wr(CB, BON);
        rd("csr_a", CA, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
